//--- rtl/oic_top.sv
`timescale 1ns/100ps
`include "oic_defs.svh"
module oic_top #(
  parameter int SETTLE_CYC = `OIC_SETTLE_CYC,
  parameter int STRAP_CYC = `OIC_STRAP_CYC
) (
  // clock and hardware reset
  input wire logic clk,
  input wire logic rstn,
  // management pins
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  // straps and supply sense
  input wire logic [1:0] configStrap,
  input wire logic io18Sense,
  // calibration replica
  input wire logic cmpStrong,
  output logic [3:0] replicaCode,
  output logic replicaLeg,
  output logic [2:0] replicaTarget,
  // pad finger drive
  output logic [3:0] padPullUp,
  output logic [3:0] padPullDown
);
  localparam int SYNC_W = 6;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 6'h03;

  logic [SYNC_W-1:0] syncPins;
  wire logic [SYNC_W-1:0] syncS2;
  logic mdcDly;
  logic mdcRise;
  logic mdioBit;
  logic v18;
  logic cmpSync;
  logic [1:0] strapLive;

  logic [15:0] strapCnt;
  logic strapDone;
  logic strapCapP;
  logic [1:0] strapBits;
  logic [4:0] phyAddr;

  logic [4:0] regAddr;
  logic [15:0] wrData;
  logic wrEn;
  logic [15:0] rdData;
  logic wrCtrl;
  logic wrTgt;
  logic wrPage;

  logic [7:0] page_reg;
  logic restart_reg;
  logic done_reg;
  logic supply_reg;
  logic [3:0] up_reg;
  logic [3:0] dn_reg;
  logic rsv_reg;
  logic force_reg;
  logic [2:0] target_reg;
  logic calStart;

  logic engBusy;
  logic engDone;
  logic [3:0] engUp;
  logic [3:0] engDn;
  logic [3:0] padUp_next;
  logic [3:0] padDn_next;

  // pin synchronisers, reset to idle pin levels so no false mdc edge
  assign syncPins = {cmpStrong, io18Sense, configStrap, mdioIn, mdc};

  generate
    for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
      logic stage1;
      logic stage2;
      always_ff @(posedge clk) begin
        if (!rstn) begin
          stage1 <= SYNC_IDLE[i];
          stage2 <= SYNC_IDLE[i];
        end else begin
          stage1 <= syncPins[i];
          stage2 <= stage1;
        end
      end
      assign syncS2[i] = stage2;
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mdcDly <= 1'b1;
    end else begin
      mdcDly <= syncS2[0];
    end
  end

  assign mdcRise = syncS2[0] && !mdcDly;
  assign mdioBit = syncS2[1];
  assign strapLive = syncS2[3:2];
  assign v18 = syncS2[4];
  assign cmpSync = syncS2[5];

  // strap capture a fixed delay after reset release
  always_ff @(posedge clk) begin
    strapCapP <= 1'b0;
    if (!rstn) begin
      strapCnt <= 16'h0000;
      strapDone <= 1'b0;
      strapBits <= 2'h0;
    end else if (!strapDone) begin
      strapCnt <= strapCnt + 16'h0001;
      if (strapCnt == 16'(STRAP_CYC - 1)) begin
        strapDone <= 1'b1;
        strapBits <= strapLive;
        strapCapP <= 1'b1;
      end
    end
  end

  assign phyAddr = {`OIC_PHY_ADDR_HI, strapBits[0]};

  // management frame decoder
  oic_mdio_slave u_mdio (
    .clk(clk),
    .rstn(rstn),
    .mdcRise(mdcRise),
    .mdioBit(mdioBit),
    .mdioOut(mdioOut),
    .mdioOe(mdioOe),
    .phyAddr(phyAddr),
    .rdData(rdData),
    .regAddr(regAddr),
    .wrData(wrData),
    .wrEn(wrEn)
  );

  assign wrPage = wrEn && regAddr == `OIC_REG_PAGE;
  assign wrCtrl = wrEn && page_reg == `OIC_CAL_PAGE && regAddr == `OIC_REG_CTRL;
  assign wrTgt = wrEn && page_reg == `OIC_CAL_PAGE && regAddr == `OIC_REG_TGT;

  // register read mux
  always_comb begin
    rdData = 16'h0000;
    if (regAddr == `OIC_REG_PAGE) begin
      rdData = {8'h00, page_reg};
    end else if (page_reg == `OIC_CAL_PAGE && regAddr == `OIC_REG_CTRL) begin
      rdData = {restart_reg, done_reg, supply_reg, v18, up_reg, rsv_reg, force_reg, 2'h0, dn_reg};
    end else if (page_reg == `OIC_CAL_PAGE && regAddr == `OIC_REG_TGT) begin
      rdData = {13'h0000, target_reg};
    end
  end

  // page select
  always_ff @(posedge clk) begin
    if (!rstn) begin
      page_reg <= `OIC_PAGE_RST;
    end else if (wrPage) begin
      page_reg <= wrData[7:0];
    end
  end

  // restart request, clears itself one cycle later
  always_ff @(posedge clk) begin
    if (!rstn) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wrCtrl && wrData[`OIC_B_RESTART];
    end
  end

  assign calStart = restart_reg || strapCapP;

  // completion flag
  always_ff @(posedge clk) begin
    if (!rstn) begin
      done_reg <= 1'b0;
    end else if (calStart) begin
      done_reg <= 1'b0;
    end else if (engDone) begin
      done_reg <= 1'b1;
    end
  end

  // supply level, seeded from straps then software owned
  always_ff @(posedge clk) begin
    if (!rstn) begin
      supply_reg <= 1'b0;
    end else if (strapCapP) begin
      supply_reg <= strapBits[1] ^ strapBits[0];
    end else if (wrCtrl) begin
      supply_reg <= wrData[`OIC_B_SUPPLY];
    end
  end

  // finger code fields; only rstn restores defaults
  always_ff @(posedge clk) begin
    if (!rstn) begin
      up_reg <= `OIC_CODE_RST;
      dn_reg <= `OIC_CODE_RST;
    end else if (engDone) begin
      up_reg <= engUp;
      dn_reg <= engDn;
    end else if (wrCtrl) begin
      up_reg <= wrData[`OIC_F_UP];
      dn_reg <= wrData[`OIC_F_DN];
    end
  end

  // force and reserved bits
  always_ff @(posedge clk) begin
    if (!rstn) begin
      force_reg <= 1'b0;
      rsv_reg <= 1'b0;
    end else if (wrCtrl) begin
      force_reg <= wrData[`OIC_B_FORCE];
      rsv_reg <= wrData[`OIC_B_RSV];
    end
  end

  // impedance target
  always_ff @(posedge clk) begin
    if (!rstn) begin
      target_reg <= `OIC_TGT_RST;
    end else if (wrTgt) begin
      target_reg <= wrData[`OIC_F_TGT];
    end
  end

  // calibration sequencer
  oic_cal_engine #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_cal (
    .clk(clk),
    .rstn(rstn),
    .start(calStart),
    .cmpStrong(cmpSync),
    .busy(engBusy),
    .donePulse(engDone),
    .trialCode(replicaCode),
    .trialLeg(replicaLeg),
    .upCode(engUp),
    .dnCode(engDn)
  );

  assign replicaTarget = target_reg;

  // pad drive: forced fields or last automatic result
  assign padUp_next = force_reg ? up_reg : engUp;
  assign padDn_next = force_reg ? dn_reg : engDn;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      padPullUp <= `OIC_CODE_RST;
      padPullDown <= `OIC_CODE_RST;
    end else begin
      padPullUp <= padUp_next;
      padPullDown <= padDn_next;
    end
  end

  // checks
  restart_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    wrCtrl && wrData[`OIC_B_RESTART] |=> restart_reg ##1 (!restart_reg && !done_reg && engBusy))
    else $error("restart bit did not clear or start calibration");

  done_set_a: assert property (@(posedge clk) disable iff (!rstn)
    engDone && !calStart |=> done_reg && rdData[14] == (page_reg == `OIC_CAL_PAGE && regAddr == `OIC_REG_CTRL))
    else $error("completion flag not set after calibration");

  done_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    calStart |=> !done_reg throughout (engBusy [*2]))
    else $error("completion flag set during calibration");

  code_store_a: assert property (@(posedge clk) disable iff (!rstn)
    engDone |=> up_reg == $past(engUp) && dn_reg == $past(engDn))
    else $error("calibrated codes not stored");

  force_pad_a: assert property (@(posedge clk) disable iff (!rstn)
    force_reg |=> padPullUp == $past(up_reg) && padPullDown == $past(dn_reg))
    else $error("pads not driven from forced fields");

  auto_pad_a: assert property (@(posedge clk) disable iff (!rstn)
    !force_reg |=> padPullUp == $past(engUp) && padPullDown == $past(engDn))
    else $error("pads not driven from calibrated codes");

  target_rst_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> target_reg == `OIC_TGT_RST && replicaTarget == `OIC_TGT_RST)
    else $error("target not at default after reset");

  strap_seed_a: assert property (@(posedge clk) disable iff (!rstn)
    strapCapP |=> supply_reg == ^$past(strapBits))
    else $error("supply level not seeded from straps");

  auto_start_a: assert property (@(posedge clk) disable iff (!rstn)
    strapCapP |=> engBusy && !replicaLeg && target_reg == $past(target_reg))
    else $error("calibration not started after strap capture");

  strap_time_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(strapDone) |-> $past(strapCnt) == 16'(STRAP_CYC - 1))
    else $error("straps captured at wrong time");

  v18_read_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(rstn, 2) |-> v18 == $past(io18Sense, 2))
    else $error("1.8V indication not tracking its pin");
endmodule: oic_top

//--- common/oic_defs.svh
`ifndef OIC_DEFS_SVH
`define OIC_DEFS_SVH
// Overview of operation
// - calibrate automatically at 47.3 ohm after reset
// - restart bit 15 starts calibration, self-clears
// - bit 14 reads one once calibration done
// - store pull-up 11:8, pull-down 3:0 codes
// - force bit 6 drives pads from fields
// - finger code ones strongest, zeros all off
// - target field 2:0 resets to 47.3 ohm
// - supply bit 13: 0 3.3V, 1 2.5V
// - strap 00/11 gives 3.3V, 10/01 2.5V
// - bit 12 reads one on 1.8V supply
// - straps sampled shortly after reset release
// - registers reached through the management interface

// register map, page 2 (page select is reg 22)
`define OIC_REG_PAGE 5'h16
`define OIC_REG_CTRL 5'h18
`define OIC_REG_TGT 5'h19
`define OIC_CAL_PAGE 8'h02
// control and target register fields
`define OIC_B_RESTART 15
`define OIC_B_SUPPLY 13
`define OIC_B_RSV 7
`define OIC_B_FORCE 6
`define OIC_F_UP 11:8
`define OIC_F_DN 3:0
`define OIC_F_TGT 2:0
// reset values and fixed PHY address bits
`define OIC_TGT_RST 3'h3
`define OIC_CODE_RST 4'h0
`define OIC_PAGE_RST 8'h00
`define OIC_PHY_ADDR_HI 4'h0
// timing
`define OIC_CLK_NS 50
`define OIC_SETTLE_NS 1000
`define OIC_STRAP_NS 10000
`define OIC_SETTLE_CYC ((`OIC_SETTLE_NS + `OIC_CLK_NS - 1) / `OIC_CLK_NS)
`define OIC_STRAP_CYC ((`OIC_STRAP_NS + `OIC_CLK_NS - 1) / `OIC_CLK_NS)
`endif

//--- common/oic_pkg.sv
package oic_pkg;
  typedef enum logic [2:0] {
    MD_IDLE = 3'b000,
    MD_START = 3'b001,
    MD_HEAD = 3'b010,
    MD_TURN = 3'b011,
    MD_DATA = 3'b100
  } oic_mdio_state_t;
  typedef enum logic [0:0] {
    CAL_IDLE = 1'b0,
    CAL_RUN = 1'b1
  } oic_cal_state_t;
endpackage: oic_pkg

//--- rtl/oic_mdio_slave.sv
`timescale 1ns/100ps
`include "oic_defs.svh"
module oic_mdio_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // synchronised management pins
  input wire logic mdcRise,
  input wire logic mdioBit,
  output logic mdioOut,
  output logic mdioOe,
  // register side
  input wire logic [4:0] phyAddr,
  input wire logic [15:0] rdData,
  output logic [4:0] regAddr,
  output logic [15:0] wrData,
  output logic wrEn
);
  oic_pkg::oic_mdio_state_t state;
  logic [4:0] cnt;
  logic isC45;
  logic [10:0] hdr;
  logic [15:0] dataSh;
  logic [15:0] c45Addr;
  logic [1:0] op;
  logic match;
  logic reading;
  logic [11:0] hdrFull;
  logic [15:0] dataFull;

  assign hdrFull = {hdr, mdioBit};
  assign dataFull = {dataSh[14:0], mdioBit};

  // frame decoder, clause 22 and clause 45, preamble optional
  always_ff @(posedge clk) begin
    wrEn <= 1'b0;
    if (!rstn) begin
      state <= oic_pkg::MD_IDLE;
      cnt <= 5'h00;
      isC45 <= 1'b0;
      hdr <= 11'h000;
      dataSh <= 16'h0000;
      c45Addr <= 16'h0000;
      op <= 2'h0;
      match <= 1'b0;
      reading <= 1'b0;
      regAddr <= 5'h00;
      wrData <= 16'h0000;
      mdioOut <= 1'b1;
      mdioOe <= 1'b0;
    end else if (mdcRise) begin
      case (state)
        oic_pkg::MD_IDLE: begin
          if (!mdioBit) state <= oic_pkg::MD_START;
        end
        oic_pkg::MD_START: begin
          isC45 <= !mdioBit;
          cnt <= 5'h00;
          state <= oic_pkg::MD_HEAD;
        end
        oic_pkg::MD_HEAD: begin
          hdr <= hdrFull[10:0];
          cnt <= cnt + 5'h01;
          if (cnt == 5'h0B) begin
            cnt <= 5'h00;
            state <= oic_pkg::MD_TURN;
            op <= hdrFull[11:10];
            match <= hdrFull[9:5] == phyAddr;
            reading <= (hdrFull[9:5] == phyAddr) && (isC45 ? hdrFull[11] : hdrFull[11:10] == 2'h2);
            regAddr <= isC45 ? c45Addr[4:0] : hdrFull[4:0];
          end
        end
        oic_pkg::MD_TURN: begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'h00 && reading) begin
            mdioOe <= 1'b1;
            mdioOut <= 1'b0;
          end
          if (cnt == 5'h01) begin
            cnt <= 5'h00;
            state <= oic_pkg::MD_DATA;
            mdioOut <= reading ? rdData[15] : 1'b1;
            dataSh <= {rdData[14:0], 1'b0};
          end
        end
        oic_pkg::MD_DATA: begin
          cnt <= cnt + 5'h01;
          if (reading) begin
            mdioOut <= dataSh[15];
            dataSh <= {dataSh[14:0], 1'b0};
          end else begin
            dataSh <= dataFull;
          end
          if (cnt == 5'h0F) begin
            state <= oic_pkg::MD_IDLE;
            mdioOe <= 1'b0;
            mdioOut <= 1'b1;
            if (match && isC45 && op == 2'h0) c45Addr <= dataFull;
            else if (match && isC45 && op == 2'h2) c45Addr <= c45Addr + 16'h0001;
            if (match && !reading && !(isC45 && op == 2'h0)) begin
              wrEn <= 1'b1;
              wrData <= dataFull;
            end
          end
        end
        default: state <= oic_pkg::MD_IDLE;
      endcase
    end
  end
endmodule: oic_mdio_slave

//--- rtl/oic_cal_engine.sv
`timescale 1ns/100ps
`include "oic_defs.svh"
module oic_cal_engine #(
  parameter int SETTLE_CYC = `OIC_SETTLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic cmpStrong,
  output logic busy,
  output logic donePulse,
  // replica drive and results
  output logic [3:0] trialCode,
  output logic trialLeg,
  output logic [3:0] upCode,
  output logic [3:0] dnCode
);
  oic_pkg::oic_cal_state_t state;
  logic [15:0] cnt;
  logic [1:0] bitIdx;
  logic [3:0] bitMask;
  logic [3:0] decided;

  assign busy = state == oic_pkg::CAL_RUN;
  assign bitMask = 4'h1 << bitIdx;
  // keep the trial bit only while the replica is still too weak
  assign decided = cmpStrong ? trialCode : (trialCode & ~bitMask);

  // successive approximation, pull-up leg first, then pull-down
  always_ff @(posedge clk) begin
    donePulse <= 1'b0;
    if (!rstn) begin
      state <= oic_pkg::CAL_IDLE;
      cnt <= 16'h0000;
      bitIdx <= 2'h3;
      trialCode <= `OIC_CODE_RST;
      trialLeg <= 1'b0;
      upCode <= `OIC_CODE_RST;
      dnCode <= `OIC_CODE_RST;
    end else if (start) begin
      state <= oic_pkg::CAL_RUN;
      cnt <= 16'h0000;
      bitIdx <= 2'h3;
      trialCode <= 4'h8;
      trialLeg <= 1'b0;
    end else begin
      case (state)
        oic_pkg::CAL_RUN: begin
          cnt <= cnt + 16'h0001;
          if (cnt == 16'(SETTLE_CYC - 1)) begin
            cnt <= 16'h0000;
            bitIdx <= bitIdx - 2'h1;
            trialCode <= decided | (bitMask >> 1);
            if (bitIdx == 2'h0) begin
              trialCode <= 4'h8;
              trialLeg <= 1'b1;
              if (!trialLeg) begin
                upCode <= decided;
              end else begin
                dnCode <= decided;
                donePulse <= 1'b1;
                state <= oic_pkg::CAL_IDLE;
              end
            end
          end
        end
        default: state <= oic_pkg::CAL_IDLE;
      endcase
    end
  end

  cal_leg_order_a: assert property (@(posedge clk) disable iff (!rstn)
    donePulse |-> $past(trialLeg) && !busy) else $error("done without pull-down leg");
endmodule: oic_cal_engine

//--- tb/output_impedance_calibration_bench.sv
`timescale 1ns/100ps
`include "oic_defs.svh"
module output_impedance_calibration_bench;
  localparam int SETTLE = 100;
  localparam int STRAP = 4;
  logic clk, rstn, mdc, mdioOut, mdioOe, io18Sense, cmpStrong, replicaLeg;
  logic benchOe, benchBit, mdioLine, taSeen;
  logic [1:0] configStrap;
  logic [3:0] replicaCode, padPullUp, padPullDown, goalUp, goalDn, mu, md;
  logic [2:0] replicaTarget;
  logic [4:0] phyOwn;
  logic [15:0] v;
  int miscompares = 0;
  int nTests = 0;

  assign mdioLine = mdioOe ? mdioOut : (benchOe ? benchBit : 1'b1);

  oic_top #(.SETTLE_CYC(SETTLE), .STRAP_CYC(STRAP)) i_dut (
    .clk(clk), .rstn(rstn), .mdc(mdc), .mdioIn(mdioLine), .mdioOut(mdioOut), .mdioOe(mdioOe),
    .configStrap(configStrap), .io18Sense(io18Sense), .cmpStrong(cmpStrong),
    .replicaCode(replicaCode), .replicaLeg(replicaLeg), .replicaTarget(replicaTarget),
    .padPullUp(padPullUp), .padPullDown(padPullDown));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // replica: trial kept while code not above the goal of the leg
  always @(posedge clk) cmpStrong <= (replicaCode <= (replicaLeg ? goalDn : goalUp));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask: check

  task automatic close_out();
    $display("checks %0d, mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask: close_out

  task automatic mdio_bit(input logic drv, input logic val, output logic seen);
    mdc <= 1'b0;
    benchOe <= drv;
    benchBit <= val;
    repeat (4) @(posedge clk);
    @(negedge clk);
    seen = mdioLine;
    @(posedge clk);
    mdc <= 1'b1;
    repeat (5) @(posedge clk);
  endtask: mdio_bit

  // stOp: start and op bits, 0101/0110 short frames, 00xx long frames
  task automatic mdio_xfer(input logic [3:0] stOp, input logic [4:0] phy, input logic [4:0] addr,
                           input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] hdr;
    logic s;
    logic isRd;
    isRd = (stOp == 4'b0110) || (stOp[3:1] == 3'b001);
    hdr = {stOp, phy, addr, isRd ? 2'b11 : 2'b10, isRd ? 16'hFFFF : wd};
    rd = 16'h0000;
    for (int i = 31; i >= 0; i--) begin
      mdio_bit(!(isRd && i < 18), hdr[i], s);
      if (i == 16) taSeen = s;
      if (i < 16) rd[i] = s;
    end
    mdio_bit(1'b0, 1'b1, s);
  endtask: mdio_xfer

  task automatic rd_reg(input logic [4:0] addr, output logic [15:0] rd);
    mdio_xfer(4'b0110, phyOwn, addr, 16'h0000, rd);
  endtask: rd_reg

  task automatic wr_reg(input logic [4:0] addr, input logic [15:0] wd);
    logic [15:0] dummy;
    mdio_xfer(4'b0101, phyOwn, addr, wd, dummy);
  endtask: wr_reg

  task automatic wait_done(output logic [15:0] rd);
    for (int k = 0; k < 8; k++) begin
      rd_reg(`OIC_REG_CTRL, rd);
      if (rd[14] === 1'b1) break;
    end
  endtask: wait_done

  function automatic logic [15:0] ctrl_exp(logic done, logic sup, logic io, logic [3:0] up, logic rsv,
                                           logic frc, logic [3:0] dn);
    return {1'b0, done, sup, io, up, rsv, frc, 2'b00, dn};
  endfunction: ctrl_exp

  task automatic hw_reset(input logic [1:0] strap);
    rstn <= 1'b0;
    configStrap <= strap;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check("reset target", {13'h0000, replicaTarget}, 16'h0003);
    check("reset pads", {8'h00, padPullUp, padPullDown}, 16'h0000);
    check("reset replica", {11'h000, replicaLeg, replicaCode}, 16'h0000);
    check("reset mdio", {14'h0000, mdioOe, mdioOut}, 16'h0001);
    repeat (STRAP + 10) @(posedge clk);
    phyOwn = {4'h0, strap[0]};
  endtask: hw_reset

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    logic [2:0] t;
    logic [1:0] s;
    mdc = 1'b1;
    benchOe = 1'b0;
    benchBit = 1'b1;
    phyOwn = 5'h00;
    void'($urandom(11374));
    for (int n = 0; n < 4; n++) begin
      s = 2'(n);
      goalUp = (n == 0) ? 4'hF : 4'($urandom);
      goalDn = (n == 0) ? 4'h0 : 4'($urandom);
      io18Sense <= 1'($urandom);
      hw_reset(s);
      rd_reg(`OIC_REG_CTRL, v);
      check("ctrl off page", v, 16'h0000);
      check("turnaround", {15'h0000, taSeen}, 16'h0000);
      wr_reg(`OIC_REG_PAGE, {8'h00, `OIC_CAL_PAGE});
      rd_reg(`OIC_REG_TGT, v);
      check("target reset", v, 16'h0003);
      wait_done(v);
      check("auto ctrl", v, ctrl_exp(1'b1, ^s, io18Sense, goalUp, 1'b0, 1'b0, goalDn));
      check("auto pads", {8'h00, padPullUp, padPullDown}, {8'h00, goalUp, goalDn});
      mdio_xfer(4'b0110, phyOwn ^ 5'h01, `OIC_REG_CTRL, 16'h0000, v);
      check("foreign ta", {15'h0000, taSeen}, 16'h0001);
      check("foreign data", v, 16'hFFFF);
      $display("reset and auto calibration done, strap %0d", n);
      if (n == 0) begin
        for (int k = 0; k < 8; k++) begin
          wr_reg(`OIC_REG_TGT, {13'h0000, 3'(k)});
          rd_reg(`OIC_REG_TGT, v);
          check("target code", v, {13'h0000, 3'(k)});
          check("target pin", {13'h0000, replicaTarget}, {13'h0000, 3'(k)});
        end
        // long frames: address, write, read, read with increment
        mdio_xfer(4'b0000, phyOwn, 5'h01, {11'h000, `OIC_REG_TGT}, v);
        mdio_xfer(4'b0001, phyOwn, 5'h01, 16'h0005, v);
        check("c45 target", {13'h0000, replicaTarget}, 16'h0005);
        mdio_xfer(4'b0011, phyOwn, 5'h01, 16'h0000, v);
        check("c45 read", v, 16'h0005);
        mdio_xfer(4'b0010, phyOwn, 5'h01, 16'h0000, v);
        check("c45 incr read", v, 16'h0005);
        mdio_xfer(4'b0011, phyOwn, 5'h01, 16'h0000, v);
        check("c45 next reg", v, 16'h0000);
        $display("long frame access done");
      end
      t = 3'($urandom);
      wr_reg(`OIC_REG_TGT, {13'h0000, t});
      check("replica target", {13'h0000, replicaTarget}, {13'h0000, t});
      mu = goalUp;
      md = goalDn;
      goalUp = 4'($urandom);
      goalDn = 4'($urandom);
      wr_reg(`OIC_REG_CTRL, 16'h8000);
      rd_reg(`OIC_REG_CTRL, v);
      check("restart ctrl", v, ctrl_exp(1'b0, 1'b0, io18Sense, 4'h0, 1'b0, 1'b0, 4'h0));
      check("pads hold", {8'h00, padPullUp, padPullDown}, {8'h00, mu, md});
      wait_done(v);
      check("rerun ctrl", v, ctrl_exp(1'b1, 1'b0, io18Sense, goalUp, 1'b0, 1'b0, goalDn));
      check("rerun pads", {8'h00, padPullUp, padPullDown}, {8'h00, goalUp, goalDn});
      $display("target change and restart done");
      mu = 4'($urandom);
      md = 4'($urandom);
      wr_reg(`OIC_REG_CTRL, {4'h7, mu, 4'hF, md});
      rd_reg(`OIC_REG_CTRL, v);
      check("forced ctrl", v, ctrl_exp(1'b1, 1'b1, io18Sense, mu, 1'b1, 1'b1, md));
      check("forced pads", {8'h00, padPullUp, padPullDown}, {8'h00, mu, md});
      wr_reg(`OIC_REG_CTRL, {4'h0, mu, 4'h0, md});
      rd_reg(`OIC_REG_CTRL, v);
      check("unforced ctrl", v, ctrl_exp(1'b1, 1'b0, io18Sense, mu, 1'b0, 1'b0, md));
      check("unforced pads", {8'h00, padPullUp, padPullDown}, {8'h00, goalUp, goalDn});
      $display("manual force done");
    end
    close_out();
  end
endmodule: output_impedance_calibration_bench
